//--- evie_regs.vh
// Purpose: Constants for the event interrupt enable block: register map, bit
//          positions, reset values and bus response codes.
// Assumes: 32-bit AXI4-Lite data, each register in one aligned word.
// Notes:   Flag bits sit at the same positions as their enable bits.
// Notes on behaviour
// - Per-source enables: tx abort 2, rx abort 1, full 0.
// - Nothing reaches the interrupt without global bit 15.
// - Exponentiation start bit falling sets a sticky flag.
// - Enable bit 14 gates the exponentiation flag.
// - Each finished hash block or calculation sets flag.
// - Enable bit 13 gates the hash flag.
// - Cipher start bit 11 falling sets a sticky flag.
// - Enable bit 12 gates the cipher flag.
// - Link established or lost sets a sticky flag.
// - Status bit 8 shows current link state.
// - Enable bit 11 gates the link change flag.
// - Pending enabled events drive the interrupt pin.
`ifndef EVIE_REGS_VH
`define EVIE_REGS_VH

`define EVIE_ADDR_W        8
`define EVIE_ADDR_ENABLE   8'h00
`define EVIE_ADDR_FLAG     8'h04
`define EVIE_ADDR_STATUS   8'h08
`define EVIE_ADDR_CONTROL  8'h0C

`define EVIE_BIT_GLOBAL    15
`define EVIE_BIT_MODEXP    14
`define EVIE_BIT_DIGEST    13
`define EVIE_BIT_CIPHER    12
`define EVIE_BIT_LINK      11
`define EVIE_BIT_TXABT     2
`define EVIE_BIT_RXABT     1
`define EVIE_BIT_PCFULL    0

`define EVIE_BIT_LINK_UP   8
`define EVIE_CTL_MODEXP    15
`define EVIE_CTL_CIPHER    11

`define EVIE_ENABLE_MASK   16'hF807
`define EVIE_FLAG_MASK     16'h7807
`define EVIE_ENABLE_RESET  16'h0000
`define EVIE_FLAG_RESET    16'h0000
`define EVIE_PKT_FULL      8'hFF

`define EVIE_RESP_OKAY     2'h0
`define EVIE_RESP_SLVERR   2'h2

`endif

//--- evie_sync.v
// Purpose: Three-stage synchroniser with agreement filter for one pin.
// Assumes: The pin is asynchronous to aclk.
// Notes:   The output changes only when stages two and three agree.
`timescale 1ns/10ps
module evie_sync
(
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  output reg  level
);

  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
      begin
        level <= stage3;
      end
    end
  end

endmodule

//--- evie_fall.v
// Purpose: Registered one-cycle pulse on a falling edge of a level.
// Assumes: The level comes from logic on aclk.
// Notes:   A level low out of reset does not produce a pulse.
`timescale 1ns/10ps
module evie_fall
(
  input  wire aclk,
  input  wire aresetn,
  input  wire level,
  output reg  pulse
);

  reg prev;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev  <= 1'b0;
      pulse <= 1'b0;
    end
    else
    begin
      prev  <= level;
      pulse <= prev & ~level;
    end
  end

endmodule

//--- evie_event_irq.v
// Purpose: Interrupt enable, flag and status logic with an AXI4-Lite slave.
// Assumes: Engine done and abort events are one-cycle pulses on aclk; the
//          start bits are levels owned by the engines; link_up_pin is async.
// Notes:   Flags other than the live full flag are sticky and cleared by writing one; set beats clear.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "evie_regs.vh"
module evie_event_irq
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        modexp_start_bit,
  input  wire        cipher_start_bit,
  input  wire        digest_done,
  input  wire        tx_abort_event,
  input  wire        rx_abort_event,
  input  wire [7:0]  pkt_count,
  input  wire        link_up_pin,
  output reg         irq
);

  // Merges write data into a 16-bit register under the two low byte lanes.
  // Upper lanes are ignored since every register here is 16 bits wide.
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] data;
    input [3:0]  strb;
    begin
      lane_merge = old;
      if (strb[0])
      begin
        lane_merge[7:0] = data[7:0];
      end
      if (strb[1])
      begin
        lane_merge[15:8] = data[15:8];
      end
    end
  endfunction

  // Ones written under enabled lanes, used for write-one-to-clear.
  function [15:0] lane_ones;
    input [15:0] data;
    input [3:0]  strb;
    begin
      lane_ones = lane_merge(16'h0000, data, strb);
    end
  endfunction

  // True for the four word addresses that hold a register.
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `EVIE_ADDR_ENABLE) || (addr == `EVIE_ADDR_FLAG) ||
               (addr == `EVIE_ADDR_STATUS) || (addr == `EVIE_ADDR_CONTROL);
    end
  endfunction

  reg  [15:0] event_enable_reg;
  reg  [15:0] event_flag_reg;
  reg  [15:0] next_event_flag_reg;
  reg  [15:0] next_event_enable_reg;
  reg  [15:0] set_vec;

  // Write channel holding state: either beat may arrive first.
  reg         aw_held;
  reg  [7:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire        link_up_status;
  reg         link_prev;
  reg         link_change;
  wire        modexp_done;
  wire        cipher_done;
  wire        pkt_counter_full;
  wire        do_write;
  wire [7:0]  wr_addr;
  wire [15:0] wr_data;
  wire [3:0]  wr_strb;
  wire [15:0] ethernet_status_reg;
  wire [15:0] control_reg_one;
  wire [15:0] flag_view;
  wire        global_irq_enable;
  wire        next_irq;

  // The link pin is the only input from outside the clock domain.
  evie_sync u_link_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (link_up_pin),
    .level   (link_up_status)
  );

  // The flag follows the engine clearing its own start bit on completion.
  evie_fall u_modexp_fall
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (modexp_start_bit),
    .pulse   (modexp_done)
  );

  evie_fall u_cipher_fall
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (cipher_start_bit),
    .pulse   (cipher_done)
  );

  // Either direction of the filtered link level counts as a change.
  // A bounce shorter than the synchroniser's agreement window is filtered
  // out, so it raises no flag.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_prev   <= 1'b0;
      link_change <= 1'b0;
    end
    else
    begin
      link_prev   <= link_up_status;
      link_change <= link_prev ^ link_up_status;
    end
  end

  // The full flag is live: it drops as soon as the count is decremented.
  // Software cannot clear it, since it is never latched.
  assign pkt_counter_full = (pkt_count == `EVIE_PKT_FULL);

  // Write address and data are taken in either order and held until both
  // are present; the response blocks further writes until it is taken.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // A beat taken in this very cycle is used directly, so no cycle is lost.
  assign wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data  = w_held ? w_data[15:0] : s_axi_wdata[15:0];
  assign wr_strb  = w_held ? w_strb : s_axi_wstrb;
  assign do_write = (aw_held || (s_axi_awvalid && s_axi_awready)) &&
                    (w_held || (s_axi_wvalid && s_axi_wready)) &&
                    !s_axi_bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EVIE_RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_addr) ? `EVIE_RESP_OKAY : `EVIE_RESP_SLVERR;
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Events collected into one vector at the positions of their enables.
  // Bit 0 stays out: the full condition is live and never latched.
  always @*
  begin
    set_vec = 16'h0000;
    set_vec[`EVIE_BIT_MODEXP] = modexp_done;
    set_vec[`EVIE_BIT_DIGEST] = digest_done;
    set_vec[`EVIE_BIT_CIPHER] = cipher_done;
    set_vec[`EVIE_BIT_LINK]   = link_change;
    set_vec[`EVIE_BIT_TXABT]  = tx_abort_event;
    set_vec[`EVIE_BIT_RXABT]  = rx_abort_event;
  end

  // Software can only clear a flag; an event in the clearing cycle keeps
  // it set so that no completion is lost.
  always @*
  begin
    next_event_flag_reg = event_flag_reg;
    if (do_write && (wr_addr == `EVIE_ADDR_FLAG))
    begin
      next_event_flag_reg = event_flag_reg & ~lane_ones(wr_data, wr_strb);
    end
    next_event_flag_reg = (next_event_flag_reg | set_vec) & `EVIE_FLAG_MASK;
  end

  // Reserved enable bits read back as zero whatever is written.
  always @*
  begin
    next_event_enable_reg = event_enable_reg;
    if (do_write && (wr_addr == `EVIE_ADDR_ENABLE))
    begin
      next_event_enable_reg = lane_merge(event_enable_reg, wr_data, wr_strb) &
                              `EVIE_ENABLE_MASK;
    end
  end

  // Both registers load every cycle; the next values hold them when idle.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_flag_reg   <= `EVIE_FLAG_RESET;
      event_enable_reg <= `EVIE_ENABLE_RESET;
    end
    else
    begin
      event_flag_reg   <= next_event_flag_reg;
      event_enable_reg <= next_event_enable_reg;
    end
  end

  // The full flag is not stored; it is merged into the view at read time.
  assign flag_view = event_flag_reg |
                     ({15'h0000, pkt_counter_full} << `EVIE_BIT_PCFULL);

  assign ethernet_status_reg = ({15'h0000, link_up_status} << `EVIE_BIT_LINK_UP) |
                               {8'h00, pkt_count};

  assign control_reg_one = ({15'h0000, modexp_start_bit} << `EVIE_CTL_MODEXP) |
                           ({15'h0000, cipher_start_bit} << `EVIE_CTL_CIPHER);

  // Reads answer one cycle after the address is taken; one at a time.
  // The word reflects register state before the accepting edge; a flag set
  // at that edge shows on the next read.
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `EVIE_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `EVIE_RESP_OKAY;
        case (s_axi_araddr)
          `EVIE_ADDR_ENABLE:
            s_axi_rdata <= {16'h0000, event_enable_reg};
          `EVIE_ADDR_FLAG:
            s_axi_rdata <= {16'h0000, flag_view};
          `EVIE_ADDR_STATUS:
            s_axi_rdata <= {16'h0000, ethernet_status_reg};
          `EVIE_ADDR_CONTROL:
            s_axi_rdata <= {16'h0000, control_reg_one};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `EVIE_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Each flag is gated by its own enable; the global bit gates them all.
  assign global_irq_enable = event_enable_reg[`EVIE_BIT_GLOBAL];

  assign next_irq = global_irq_enable &&
                    ((flag_view[`EVIE_BIT_MODEXP] &&
                      event_enable_reg[`EVIE_BIT_MODEXP]) ||
                     (flag_view[`EVIE_BIT_DIGEST] &&
                      event_enable_reg[`EVIE_BIT_DIGEST]) ||
                     (flag_view[`EVIE_BIT_CIPHER] &&
                      event_enable_reg[`EVIE_BIT_CIPHER]) ||
                     (flag_view[`EVIE_BIT_LINK] &&
                      event_enable_reg[`EVIE_BIT_LINK]) ||
                     (flag_view[`EVIE_BIT_TXABT] &&
                      event_enable_reg[`EVIE_BIT_TXABT]) ||
                     (flag_view[`EVIE_BIT_RXABT] &&
                      event_enable_reg[`EVIE_BIT_RXABT]) ||
                     (flag_view[`EVIE_BIT_PCFULL] &&
                      event_enable_reg[`EVIE_BIT_PCFULL]));

  // Registered so the pin never glitches on decode; costs one cycle.
  // Software that clears a flag and looks at the pin at once may still see
  // it high for that one cycle.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= next_irq;
    end
  end

endmodule

//--- evie_props.sv
// Purpose: Concurrent checks on the ports of the event interrupt block.
// Assumes: The master offers write address and write data together.
// Notes:   The enable register is shadowed from observed writes, so no internal probe is needed.
`timescale 1ns/10ps
`include "evie_regs.vh"
module evie_props
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        modexp_start_bit,
  input wire logic        cipher_start_bit,
  input wire logic        digest_done,
  input wire logic        tx_abort_event,
  input wire logic        rx_abort_event,
  input wire logic [7:0]  pkt_count,
  input wire logic        link_up_pin,
  input wire logic        irq
);
  logic [15:0] en;
  wire         wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      en <= 16'h0000;
    else if (wr_both && s_axi_awaddr == `EVIE_ADDR_ENABLE)
      en <= {s_axi_wstrb[1] ? s_axi_wdata[15:8] : en[15:8],
             s_axi_wstrb[0] ? s_axi_wdata[7:0] : en[7:0]} & `EVIE_ENABLE_MASK;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_write;
    wr_both;
  endsequence
  sequence s_modexp_end;
    $fell(modexp_start_bit) && en[14] && en[15];
  endsequence
  sequence s_cipher_end;
    $fell(cipher_start_bit) && en[12] && en[15];
  endsequence

  a_write_answer: assert property (s_write |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_global_gate: assert property (!en[15] |=> !irq)
    else $error("interrupt without global enable");
  a_txabt_irq: assert property (tx_abort_event && en[2] && en[15] |-> ##[1:2] irq)
    else $error("tx abort did not interrupt");
  a_rxabt_irq: assert property (rx_abort_event && en[1] && en[15] |-> ##[1:2] irq)
    else $error("rx abort did not interrupt");
  a_full_irq: assert property (pkt_count == 8'hFF && en[0] && en[15] |-> ##[1:2] irq)
    else $error("counter full did not interrupt");
  a_digest_irq: assert property (digest_done && en[13] && en[15] |-> ##[1:2] irq)
    else $error("hash done did not interrupt");
  a_modexp_irq: assert property (s_modexp_end |-> ##[1:4] irq)
    else $error("exponentiation end did not interrupt");
  a_cipher_irq: assert property (s_cipher_end |-> ##[1:4] irq)
    else $error("cipher end did not interrupt");
  a_link_irq: assert property ($changed(link_up_pin) && en[11] && en[15] |-> ##[1:8] irq)
    else $error("link change did not interrupt");
endmodule

//--- evie_host.sv
// Purpose: Host model that reaches the registers over the AXI4-Lite bus.
// Assumes: One write and one read at most under way.
// Notes:   Each channel is released at the edge where it is taken.
`timescale 1ns/10ps
module evie_host
(
  input  wire logic        aclk,
  output logic [7:0]  s_axi_awaddr = 8'h00,
  output logic [2:0]  s_axi_awprot = 3'h0,
  output logic        s_axi_awvalid = 1'b0,
  input  wire logic        s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0000_0000,
  output logic [3:0]  s_axi_wstrb = 4'h0,
  output logic        s_axi_wvalid = 1'b0,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic        s_axi_bready = 1'b0,
  output logic [7:0]  s_axi_araddr = 8'h00,
  output logic [2:0]  s_axi_arprot = 3'h0,
  output logic        s_axi_arvalid = 1'b0,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  output logic        s_axi_rready = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic aw_done;
    logic w_done;
    begin
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
        @(posedge aclk);
        if (!aw_done && s_axi_awready)
        begin
          aw_done = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (!w_done && s_axi_wready)
        begin
          w_done = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      while (!s_axi_bvalid)
        @(posedge aclk);
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
        @(posedge aclk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      while (!s_axi_rvalid)
        @(posedge aclk);
      s_axi_rready <= 1'b0;
    end
  endtask
endmodule

//--- evie_event_irq_bench.sv
// Purpose: Self-checking bench for the event interrupt block.
// Assumes: Start bits run two to five cycles in fire; pulses last one cycle.
// Notes:   Reads are checked by a watcher against a queue of expected words.
`timescale 1ns/10ps
`include "evie_regs.vh"
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module evie_event_irq_bench;
  logic        aclk, aresetn, modexp_start_bit, cipher_start_bit, digest_done, irq;
  logic        tx_abort_event, rx_abort_event, link_up_pin, s_axi_bready, s_axi_rready;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pkt_count, pkt;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [33:0] want;
  logic [33:0] exp_q[$];
  logic [1:0]  bwant;
  logic [1:0]  bexp_q[$];
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          bits[6] = '{2, 1, 13, 14, 12, 11};

  evie_event_irq i_evie_event_irq (.*);
  evie_host i_evie_host (.*);

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // A hang counts as a mismatch and ends the run through the same report.
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      close_out();
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      want = exp_q.pop_front();
      `CHK("read word", want, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bwant = bexp_q.pop_front();
      `CHK("write response", bwant, s_axi_bresp)
    end
  end

  task automatic rd_exp(input logic [7:0] a, input logic [1:0] rs, input logic [15:0] e);
    begin
      exp_q.push_back({rs, 16'h0000, e});
      i_evie_host.rd(a);
    end
  endtask

  task automatic wr_exp(input logic [7:0] a, input logic [15:0] d, input logic [1:0] rs);
    begin
      bexp_q.push_back(rs);
      i_evie_host.wr(a, d);
    end
  endtask

  task automatic fire(input int k);
    begin
      @(posedge aclk);
      case (k)
        0: tx_abort_event <= 1'b1;
        1: rx_abort_event <= 1'b1;
        2: digest_done <= 1'b1;
        3: modexp_start_bit <= 1'b1;
        4: cipher_start_bit <= 1'b1;
        default: link_up_pin <= ~link_up_pin;
      endcase
      @(posedge aclk);
      tx_abort_event <= 1'b0;
      rx_abort_event <= 1'b0;
      digest_done <= 1'b0;
      repeat (1 + $urandom % 4) @(posedge aclk);
      modexp_start_bit <= 1'b0;
      cipher_start_bit <= 1'b0;
      repeat (8) @(posedge aclk);
    end
  endtask

  initial
  begin
    aresetn = 1'b0;
    {modexp_start_bit, cipher_start_bit, digest_done} = 3'h0;
    {tx_abort_event, rx_abort_event, link_up_pin} = 3'h0;
    pkt_count = 8'h00;
    void'($urandom(45));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_exp(`EVIE_ADDR_ENABLE, `EVIE_RESP_OKAY, `EVIE_ENABLE_RESET);
    r = $urandom;
    wr_exp(`EVIE_ADDR_ENABLE, r[15:0], `EVIE_RESP_OKAY);
    rd_exp(`EVIE_ADDR_ENABLE, `EVIE_RESP_OKAY, r[15:0] & `EVIE_ENABLE_MASK);
    wr_exp(8'h10, ~r[15:0], `EVIE_RESP_SLVERR);
    rd_exp(`EVIE_ADDR_ENABLE, `EVIE_RESP_OKAY, r[15:0] & `EVIE_ENABLE_MASK);
    rd_exp(8'h10, `EVIE_RESP_SLVERR, 16'h0000);
    wr_exp(`EVIE_ADDR_ENABLE, 16'h0000, `EVIE_RESP_OKAY);
    modexp_start_bit <= 1'b1;
    cipher_start_bit <= 1'b1;
    rd_exp(`EVIE_ADDR_CONTROL, `EVIE_RESP_OKAY, 16'h8800);
    modexp_start_bit <= 1'b0;
    cipher_start_bit <= 1'b0;
    repeat (4) @(posedge aclk);
    `CHK("irq disabled", 1'b0, irq)
    rd_exp(`EVIE_ADDR_FLAG, `EVIE_RESP_OKAY, 16'h5000);
    wr_exp(`EVIE_ADDR_FLAG, 16'h5000, `EVIE_RESP_OKAY);
    rd_exp(`EVIE_ADDR_FLAG, `EVIE_RESP_OKAY, 16'h0000);
    $display("test registers done");
    for (int k = 0; k < 6; k++)
    begin
      wr_exp(`EVIE_ADDR_ENABLE, 16'h8000 | (16'h0001 << bits[k]), `EVIE_RESP_OKAY);
      fire(k);
      `CHK("irq raised", 1'b1, irq)
      rd_exp(`EVIE_ADDR_FLAG, `EVIE_RESP_OKAY, 16'h0001 << bits[k]);
      wr_exp(`EVIE_ADDR_FLAG, 16'h0001 << bits[k], `EVIE_RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK("irq cleared", 1'b0, irq)
    end
    rd_exp(`EVIE_ADDR_STATUS, `EVIE_RESP_OKAY, 16'h0100);
    $display("test sources done");
    wr_exp(`EVIE_ADDR_ENABLE, 16'h7807, `EVIE_RESP_OKAY);
    fire(5);
    `CHK("irq gated", 1'b0, irq)
    rd_exp(`EVIE_ADDR_FLAG, `EVIE_RESP_OKAY, 16'h0800);
    wr_exp(`EVIE_ADDR_ENABLE, 16'hF805, `EVIE_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("irq global on", 1'b1, irq)
    wr_exp(`EVIE_ADDR_FLAG, 16'h0800, `EVIE_RESP_OKAY);
    fire(1);
    `CHK("irq masked", 1'b0, irq)
    rd_exp(`EVIE_ADDR_FLAG, `EVIE_RESP_OKAY, 16'h0002);
    wr_exp(`EVIE_ADDR_FLAG, 16'h0002, `EVIE_RESP_OKAY);
    $display("test gating done");
    wr_exp(`EVIE_ADDR_ENABLE, 16'h8001, `EVIE_RESP_OKAY);
    pkt_count <= 8'hFF;
    repeat (3) @(posedge aclk);
    `CHK("irq full", 1'b1, irq)
    rd_exp(`EVIE_ADDR_FLAG, `EVIE_RESP_OKAY, 16'h0001);
    pkt = $urandom % 255;
    pkt_count <= pkt;
    repeat (3) @(posedge aclk);
    `CHK("irq not full", 1'b0, irq)
    rd_exp(`EVIE_ADDR_STATUS, `EVIE_RESP_OKAY, {8'h00, pkt});
    repeat (4) @(posedge aclk);
    $display("test counter done");
    close_out();
  end
endmodule

bind evie_event_irq evie_props i_evie_props (.*);
